/* File: hw/ext_bus_regs.svh */
// ext_bus_regs.svh: constants of the external bus strobe and select logic
// assumes: included by bare name from the package, interface and both ends
`ifndef EXT_BUS_REGS_SVH
`define EXT_BUS_REGS_SVH
`define ADDR_W        32
`define DATA_W        64
`define BANK_HI       31
`define BANK_LO       26
`define BANK0_PAT     6'h02
`define BANK1_PAT     6'h03
`define HOST_HI       31
`define HOST_LO       28
`define HOST_ZERO     4'h0
`define WORD_STEP     32'h0000_0001
`define BOOT_EPROM    1'b1
`define HANDOVER_DEF  3
`define WAIT_DEF      2
`define CNT_W         4
`define CNT_ONE       4'h1
`define CNT_ZERO      4'h0
`endif

/* File: hw/ext_bus_pkg.sv */
// ext_bus_pkg: state types of both bus ends
// assumes: nothing beyond the constant header
`include "ext_bus_regs.svh"
package ext_bus_pkg;
  typedef enum logic [2:0] {
    M_IDLE = 3'h1,
    M_ADDR = 3'h2,
    M_DATA = 3'h4
  } mst_state_t;
  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_WDATA = 4'h2,
    S_RWAIT = 4'h4,
    S_RDATA = 4'h8
  } slv_state_t;
endpackage

/* File: hw/ext_bus_if.sv */
// ext_bus_if: shared external bus, one modport per party
// assumes: pulled-up strobes and acknowledge, undriven lines read as zero
`timescale 1ns/1ps
`include "ext_bus_regs.svh"
interface ext_bus_if;
  logic [`ADDR_W-1:0] dev_addr_o, host_addr_o, addr;
  logic [`DATA_W-1:0] dev_data_o, host_data_o, data;
  logic dev_ctl_oe_n, host_ctl_oe_n, dev_data_oe_n, host_data_oe_n;
  logic dev_wrh_n_o, dev_wrl_n_o, dev_rd_n_o, dev_burst_n_o;
  logic host_wrh_n_o, host_wrl_n_o, host_rd_n_o, host_burst_n_o;
  logic wrh_n, wrl_n, rd_n, burst_n;
  logic dev_ack_o, dev_ack_oe_n, host_ack_o, host_ack_oe_n, ack;
  logic dev_bms_n_o, dev_ms0_n_o, dev_ms1_n_o, dev_msh_n_o;
  logic bms_n, ms0_n, ms1_n, msh_n, host_strap;
  logic host_req, host_grant;

  // line resolution from the enables
  assign addr    = !dev_ctl_oe_n ? dev_addr_o : (!host_ctl_oe_n ? host_addr_o : '0);
  assign data    = !dev_data_oe_n ? dev_data_o : (!host_data_oe_n ? host_data_o : '0);
  assign wrh_n   = !dev_ctl_oe_n ? dev_wrh_n_o : (!host_ctl_oe_n ? host_wrh_n_o : 1'b1);
  assign wrl_n   = !dev_ctl_oe_n ? dev_wrl_n_o : (!host_ctl_oe_n ? host_wrl_n_o : 1'b1);
  assign rd_n    = !dev_ctl_oe_n ? dev_rd_n_o : (!host_ctl_oe_n ? host_rd_n_o : 1'b1);
  assign burst_n = !dev_ctl_oe_n ? dev_burst_n_o : (!host_ctl_oe_n ? host_burst_n_o : 1'b1);
  assign ack     = !dev_ack_oe_n ? dev_ack_o : (!host_ack_oe_n ? host_ack_o : 1'b1);
  assign bms_n   = !dev_ctl_oe_n ? dev_bms_n_o : host_strap;
  assign ms0_n   = dev_ctl_oe_n | dev_ms0_n_o;
  assign ms1_n   = dev_ctl_oe_n | dev_ms1_n_o;
  assign msh_n   = dev_ctl_oe_n | dev_msh_n_o;

  modport dev (
    output dev_addr_o, dev_data_o, dev_ctl_oe_n, dev_data_oe_n, dev_wrh_n_o, dev_wrl_n_o,
    output dev_rd_n_o, dev_burst_n_o, dev_ack_o, dev_ack_oe_n, dev_bms_n_o, dev_ms0_n_o,
    output dev_ms1_n_o, dev_msh_n_o, host_grant,
    input  addr, data, wrh_n, wrl_n, rd_n, burst_n, ack, bms_n, host_req
  );
  modport host (
    output host_addr_o, host_data_o, host_ctl_oe_n, host_data_oe_n, host_wrh_n_o,
    output host_wrl_n_o, host_rd_n_o, host_burst_n_o, host_ack_o, host_ack_oe_n,
    output host_strap, host_req,
    input  addr, data, wrh_n, wrl_n, rd_n, burst_n, ack, ms0_n, ms1_n, msh_n, host_grant
  );
endinterface

/* File: hw/two_entry_buf.sv */
// two_entry_buf: two-word valid/ready buffer
// assumes: one clock, synchronous active-low reset
`timescale 1ns/1ps
module two_entry_buf #(
  parameter int W = 64
) (
  input  wire logic         I_MCLK,
  input  wire logic         I_RST_B,
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  logic [W-1:0] slot0_reg, slot0_next, slot1_reg, slot1_next;
  logic [1:0]   cnt_reg, cnt_next;
  logic         push, pop;

  if (W < 1) begin : g_chk
    $error("two_entry_buf: width must be positive");
  end

  assign o_ready = (cnt_reg != 2'h2);
  assign o_valid = (cnt_reg != 2'h0);
  assign o_data  = slot0_reg;
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;

  always_comb
  begin
    slot0_next = slot0_reg;
    slot1_next = slot1_reg;
    cnt_next   = cnt_reg + 2'(push) - 2'(pop);
    if (pop)
    begin
      slot0_next = (cnt_reg == 2'h2) ? slot1_reg : i_data;
    end
    if (push && (cnt_reg == 2'h0 || (cnt_reg == 2'h1 && pop)))
    begin
      slot0_next = i_data;
    end
    else if (push)
    begin
      slot1_next = i_data;
    end
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      cnt_reg   <= 2'h0;
      slot0_reg <= '0;
      slot1_reg <= '0;
    end
    else
    begin
      cnt_reg   <= cnt_next;
      slot0_reg <= slot0_next;
      slot1_reg <= slot1_next;
    end
  end
endmodule

/* File: hw/dev_bus_end.sv */
// dev_bus_end: processor end of the external bus, master and slave
// assumes: host end on the same clock, joined through ext_bus_if
// Function
// - high strobe for long writes and odd-word writes outside 32-bit regions
// - outside master writing upper word asserts high strobe
// - high strobe moves with address, master only
// - high strobe input marks slave writes
// - slave stalls with acknowledge low, master waits
// - acknowledge only in data phase
// - internal-memory reads may stall with acknowledge
// - never drive acknowledge on slave writes
// - boot select active through boot sequence
// - boot select sampled as strap during reset
// - bank 0 select on address pattern 000010
// - bank 1 select on address pattern 000011
// - host select when upper nibble nonzero
// - only bus master drives the selects
// - master asserts burst for consecutive addresses
// - burst slave counts addresses after first
// - slave auto-increments address during host burst
// - lines invalid during mastership handover
// - low strobe for even words, 32-bit regions
// - read strobe for every external read
`timescale 1ns/1ps
`include "ext_bus_regs.svh"
module dev_bus_end
  import ext_bus_pkg::*;
(
  input  wire logic               I_MCLK,
  input  wire logic               I_RST_B,
  ext_bus_if.dev                  BUS,
  input  wire logic               I_REQ_VALID,
  output logic                    O_REQ_READY,
  input  wire logic               I_REQ_WRITE,
  input  wire logic               I_REQ_LONG,
  input  wire logic               I_REQ_BUS32,
  input  wire logic               I_REQ_BURST,
  input  wire logic [`ADDR_W-1:0] I_REQ_ADDR,
  input  wire logic [`DATA_W-1:0] I_REQ_WDATA,
  output logic                    O_RD_VALID,
  input  wire logic               I_RD_READY,
  output logic [`DATA_W-1:0]      O_RD_DATA,
  input  wire logic               I_BOOT_DONE,
  output logic                    O_BOOT_EPROM,
  output logic                    O_HOST_GRANTED,
  output logic [`ADDR_W-1:0]      O_SLV_ADDR,
  output logic                    O_SLV_WR_VALID,
  output logic [`DATA_W-1:0]      O_SLV_WR_DATA,
  output logic                    O_SLV_WR_HI,
  output logic                    O_SLV_WR_LO,
  output logic                    O_SLV_RD_REQ,
  input  wire logic               I_SLV_RD_VALID,
  input  wire logic [`DATA_W-1:0] I_SLV_RD_DATA
);
  mst_state_t         m_state_reg, m_state_next;
  slv_state_t         s_state_reg, s_state_next;
  logic [`ADDR_W-1:0] addr_reg, addr_next, saddr_reg, saddr_next, scnt_reg, scnt_next;
  logic [`DATA_W-1:0] wdata_reg, wdata_next, srdata_reg, srdata_next, swdata_reg, swdata_next;
  logic               wrh_n_reg, wrh_n_next, wrl_n_reg, wrl_n_next, rd_n_reg, rd_n_next;
  logic               ms0_n_reg, ms0_n_next, ms1_n_reg, ms1_n_next, msh_n_reg, msh_n_next;
  logic               burst_n_reg, burst_n_next, write_reg, write_next;
  logic               grant_reg, grant_next, boot_reg, boot_next;
  logic               sburst_reg, sburst_next, swr_reg, swr_next;
  logic               shi_reg, shi_next, slo_reg, slo_next;
  logic               buf_in_valid, buf_in_ready, slv_strobe;

  // master read data path
  two_entry_buf #(.W(`DATA_W)) u_rd_buf (
    .I_MCLK  (I_MCLK),
    .I_RST_B (I_RST_B),
    .i_valid (buf_in_valid),
    .o_ready (buf_in_ready),
    .i_data  (BUS.data),
    .o_valid (O_RD_VALID),
    .i_ready (I_RD_READY),
    .o_data  (O_RD_DATA)
  );

  assign O_REQ_READY    = (m_state_reg == M_IDLE) && !grant_reg && !BUS.host_req
                          && I_RST_B && (I_REQ_WRITE || buf_in_ready);
  assign buf_in_valid   = (m_state_reg == M_DATA) && BUS.ack && !write_reg;
  assign slv_strobe     = !BUS.wrh_n || !BUS.wrl_n || !BUS.rd_n;
  assign O_BOOT_EPROM   = boot_reg;
  assign O_HOST_GRANTED = grant_reg;
  assign O_SLV_ADDR     = saddr_reg;
  assign O_SLV_WR_VALID = swr_reg;
  assign O_SLV_WR_DATA  = swdata_reg;
  assign O_SLV_WR_HI    = shi_reg;
  assign O_SLV_WR_LO    = slo_reg;
  assign O_SLV_RD_REQ   = (s_state_reg == S_RWAIT);

  // control drives: released while the host holds the bus or reset is low
  assign BUS.dev_ctl_oe_n  = grant_reg || !I_RST_B;
  assign BUS.dev_addr_o    = addr_reg;
  assign BUS.dev_wrh_n_o   = wrh_n_reg;
  assign BUS.dev_wrl_n_o   = wrl_n_reg;
  assign BUS.dev_rd_n_o    = rd_n_reg;
  assign BUS.dev_burst_n_o = burst_n_reg;
  assign BUS.dev_ms0_n_o   = ms0_n_reg;
  assign BUS.dev_ms1_n_o   = ms1_n_reg;
  assign BUS.dev_msh_n_o   = msh_n_reg;
  assign BUS.dev_bms_n_o   = !boot_reg;
  assign BUS.host_grant    = grant_reg;
  assign BUS.dev_ack_o     = 1'b0;
  assign BUS.dev_ack_oe_n  = (s_state_reg != S_RWAIT);
  assign BUS.dev_data_oe_n = !((s_state_reg == S_RDATA)
                               || (m_state_reg == M_DATA && write_reg));
  assign BUS.dev_data_o    = (s_state_reg == S_RDATA) ? srdata_reg : wdata_reg;

  // master side: strobes and selects registered with the address
  always_comb
  begin
    m_state_next = m_state_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    write_next   = write_reg;
    wrh_n_next   = wrh_n_reg;
    wrl_n_next   = wrl_n_reg;
    rd_n_next    = rd_n_reg;
    ms0_n_next   = ms0_n_reg;
    ms1_n_next   = ms1_n_reg;
    msh_n_next   = msh_n_reg;
    burst_n_next = burst_n_reg;
    grant_next   = BUS.host_req && (grant_reg || m_state_reg == M_IDLE);
    boot_next    = boot_reg && !I_BOOT_DONE;
    case (m_state_reg)
      M_IDLE:
      begin
        if (I_REQ_VALID && O_REQ_READY)
        begin
          addr_next    = I_REQ_ADDR;
          wdata_next   = I_REQ_WDATA;
          write_next   = I_REQ_WRITE;
          wrh_n_next   = !(I_REQ_WRITE && (I_REQ_LONG
                           || (I_REQ_ADDR[0] && !I_REQ_BUS32)));
          wrl_n_next   = !(I_REQ_WRITE && (I_REQ_LONG || I_REQ_BUS32
                           || !I_REQ_ADDR[0]));
          rd_n_next    = I_REQ_WRITE;
          ms0_n_next   = (I_REQ_ADDR[`BANK_HI:`BANK_LO] != `BANK0_PAT);
          ms1_n_next   = (I_REQ_ADDR[`BANK_HI:`BANK_LO] != `BANK1_PAT);
          msh_n_next   = (I_REQ_ADDR[`HOST_HI:`HOST_LO] == `HOST_ZERO);
          burst_n_next = !I_REQ_BURST;
          m_state_next = M_ADDR;
        end
        else if (grant_next)
        begin
          burst_n_next = 1'b1;
        end
      end
      M_ADDR:
      begin
        m_state_next = M_DATA;
      end
      M_DATA:
      begin
        if (BUS.ack)
        begin
          wrh_n_next   = 1'b1;
          wrl_n_next   = 1'b1;
          rd_n_next    = 1'b1;
          ms0_n_next   = 1'b1;
          ms1_n_next   = 1'b1;
          msh_n_next   = 1'b1;
          m_state_next = M_IDLE;
        end
      end
      default:
      begin
        m_state_next = M_IDLE;
      end
    endcase
  end

  // slave side: active only while the host owns the bus
  always_comb
  begin
    s_state_next = s_state_reg;
    saddr_next   = saddr_reg;
    scnt_next    = scnt_reg;
    srdata_next  = srdata_reg;
    swdata_next  = swdata_reg;
    sburst_next  = sburst_reg && grant_reg;
    swr_next     = 1'b0;
    shi_next     = shi_reg;
    slo_next     = slo_reg;
    case (s_state_reg)
      S_IDLE:
      begin
        if (grant_reg && slv_strobe)
        begin
          saddr_next   = (sburst_reg && !BUS.burst_n) ? scnt_reg : BUS.addr;
          sburst_next  = !BUS.burst_n;
          shi_next     = !BUS.wrh_n;
          slo_next     = !BUS.wrl_n;
          s_state_next = BUS.rd_n ? S_WDATA : S_RWAIT;
        end
        else if (BUS.burst_n)
        begin
          sburst_next = 1'b0;
        end
      end
      S_WDATA:
      begin
        swr_next     = 1'b1;
        swdata_next  = BUS.data;
        scnt_next    = saddr_reg + `WORD_STEP;
        s_state_next = S_IDLE;
      end
      S_RWAIT:
      begin
        if (I_SLV_RD_VALID)
        begin
          srdata_next  = I_SLV_RD_DATA;
          s_state_next = S_RDATA;
        end
      end
      S_RDATA:
      begin
        scnt_next    = saddr_reg + `WORD_STEP;
        s_state_next = S_IDLE;
      end
      default:
      begin
        s_state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      m_state_reg <= M_IDLE;
      s_state_reg <= S_IDLE;
      addr_reg    <= '0;
      wdata_reg   <= '0;
      write_reg   <= 1'b0;
      wrh_n_reg   <= 1'b1;
      wrl_n_reg   <= 1'b1;
      rd_n_reg    <= 1'b1;
      ms0_n_reg   <= 1'b1;
      ms1_n_reg   <= 1'b1;
      msh_n_reg   <= 1'b1;
      burst_n_reg <= 1'b1;
      grant_reg   <= 1'b0;
      boot_reg    <= (BUS.bms_n == `BOOT_EPROM);
      saddr_reg   <= '0;
      scnt_reg    <= '0;
      srdata_reg  <= '0;
      swdata_reg  <= '0;
      sburst_reg  <= 1'b0;
      swr_reg     <= 1'b0;
      shi_reg     <= 1'b0;
      slo_reg     <= 1'b0;
    end
    else
    begin
      m_state_reg <= m_state_next;
      s_state_reg <= s_state_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      write_reg   <= write_next;
      wrh_n_reg   <= wrh_n_next;
      wrl_n_reg   <= wrl_n_next;
      rd_n_reg    <= rd_n_next;
      ms0_n_reg   <= ms0_n_next;
      ms1_n_reg   <= ms1_n_next;
      msh_n_reg   <= msh_n_next;
      burst_n_reg <= burst_n_next;
      grant_reg   <= grant_next;
      boot_reg    <= boot_next;
      saddr_reg   <= saddr_next;
      scnt_reg    <= scnt_next;
      srdata_reg  <= srdata_next;
      swdata_reg  <= swdata_next;
      sburst_reg  <= sburst_next;
      swr_reg     <= swr_next;
      shi_reg     <= shi_next;
      slo_reg     <= slo_next;
    end
  end
endmodule

/* File: hw/host_bus_end.sv */
// host_bus_end: host end of the external bus, master of the processor
// and slave with wait states when the processor masters
// assumes: processor end on the same clock, joined through ext_bus_if
`timescale 1ns/1ps
`include "ext_bus_regs.svh"
module host_bus_end
  import ext_bus_pkg::*;
#(
  parameter int HANDOVER_CYC = `HANDOVER_DEF,
  parameter int WAIT_CYC     = `WAIT_DEF
) (
  input  wire logic               I_MCLK,
  input  wire logic               I_RST_B,
  ext_bus_if.host                 BUS,
  input  wire logic               I_BOOT_STRAP,
  input  wire logic               I_BUS_REQ,
  output logic                    O_BUS_OWNED,
  input  wire logic               I_REQ_VALID,
  output logic                    O_REQ_READY,
  input  wire logic               I_REQ_WRITE,
  input  wire logic               I_REQ_HI,
  input  wire logic               I_REQ_LO,
  input  wire logic               I_REQ_BURST,
  input  wire logic [`ADDR_W-1:0] I_REQ_ADDR,
  input  wire logic [`DATA_W-1:0] I_REQ_WDATA,
  output logic                    O_RSP_VALID,
  output logic [`DATA_W-1:0]      O_RSP_DATA,
  output logic [`ADDR_W-1:0]      O_SLV_ADDR,
  output logic                    O_SLV_WR_VALID,
  output logic [`DATA_W-1:0]      O_SLV_WR_DATA,
  input  wire logic [`DATA_W-1:0] I_SLV_RDATA
);
  mst_state_t         m_state_reg, m_state_next;
  slv_state_t         s_state_reg, s_state_next;
  logic [`ADDR_W-1:0] addr_reg, addr_next, saddr_reg, saddr_next, scnt_reg, scnt_next;
  logic [`DATA_W-1:0] wdata_reg, wdata_next, rsp_reg, rsp_next;
  logic [`DATA_W-1:0] srd_reg, srd_next, swd_reg, swd_next;
  logic [`CNT_W-1:0]  own_reg, own_next, wait_reg, wait_next;
  logic               wrh_n_reg, wrh_n_next, wrl_n_reg, wrl_n_next, rd_n_reg, rd_n_next;
  logic               burst_n_reg, burst_n_next, write_reg, write_next;
  logic               req_reg, req_next, rspv_reg, rspv_next, swr_reg, swr_next;
  logic               sburst_reg, sburst_next, owned;

  if (HANDOVER_CYC < 1 || HANDOVER_CYC > 15 || WAIT_CYC < 0 || WAIT_CYC > 15) begin : g_chk
    $error("host_bus_end: counts must fit the 4-bit counters");
  end

  assign owned          = req_reg && BUS.host_grant && (own_reg == `CNT_W'(HANDOVER_CYC));
  assign O_BUS_OWNED    = owned;
  assign O_REQ_READY    = owned && (m_state_reg == M_IDLE) && I_BUS_REQ;
  assign O_RSP_VALID    = rspv_reg;
  assign O_RSP_DATA     = rsp_reg;
  assign O_SLV_ADDR     = saddr_reg;
  assign O_SLV_WR_VALID = swr_reg;
  assign O_SLV_WR_DATA  = swd_reg;

  assign BUS.host_req       = req_reg;
  assign BUS.host_strap     = I_BOOT_STRAP;
  assign BUS.host_ctl_oe_n  = !owned;
  assign BUS.host_addr_o    = addr_reg;
  assign BUS.host_wrh_n_o   = wrh_n_reg;
  assign BUS.host_wrl_n_o   = wrl_n_reg;
  assign BUS.host_rd_n_o    = rd_n_reg;
  assign BUS.host_burst_n_o = burst_n_reg;
  assign BUS.host_data_oe_n = !((m_state_reg == M_DATA && write_reg)
                                || (s_state_reg == S_RDATA));
  assign BUS.host_data_o    = (s_state_reg == S_RDATA) ? srd_reg : wdata_reg;
  assign BUS.host_ack_oe_n  = !(s_state_reg == S_RWAIT || s_state_reg == S_RDATA);
  assign BUS.host_ack_o     = (wait_reg == `CNT_W'(WAIT_CYC));

  always_comb
  begin
    m_state_next = m_state_reg;
    addr_next    = addr_reg;
    wdata_next   = wdata_reg;
    write_next   = write_reg;
    wrh_n_next   = wrh_n_reg;
    wrl_n_next   = wrl_n_reg;
    rd_n_next    = rd_n_reg;
    burst_n_next = burst_n_reg;
    rsp_next     = rsp_reg;
    rspv_next    = 1'b0;
    req_next     = I_BUS_REQ || (m_state_reg != M_IDLE);
    own_next     = (req_reg && BUS.host_grant && own_reg != `CNT_W'(HANDOVER_CYC))
                   ? own_reg + `CNT_ONE : (BUS.host_grant && req_reg ? own_reg : `CNT_ZERO);
    case (m_state_reg)
      M_IDLE:
      begin
        if (I_REQ_VALID && O_REQ_READY)
        begin
          addr_next    = I_REQ_ADDR;
          wdata_next   = I_REQ_WDATA;
          write_next   = I_REQ_WRITE;
          wrh_n_next   = !(I_REQ_WRITE && I_REQ_HI);
          wrl_n_next   = !(I_REQ_WRITE && I_REQ_LO);
          rd_n_next    = I_REQ_WRITE;
          burst_n_next = !I_REQ_BURST;
          m_state_next = M_ADDR;
        end
      end
      M_ADDR:
      begin
        m_state_next = M_DATA;
      end
      M_DATA:
      begin
        if (BUS.ack)
        begin
          wrh_n_next   = 1'b1;
          wrl_n_next   = 1'b1;
          rd_n_next    = 1'b1;
          burst_n_next = burst_n_reg || !I_REQ_BURST;
          rsp_next     = write_reg ? rsp_reg : BUS.data;
          rspv_next    = !write_reg;
          m_state_next = M_IDLE;
        end
      end
      default:
      begin
        m_state_next = M_IDLE;
      end
    endcase
  end

  // slave of processor accesses; data phase always through wait count
  always_comb
  begin
    s_state_next = s_state_reg;
    saddr_next   = saddr_reg;
    scnt_next    = scnt_reg;
    srd_next     = srd_reg;
    swd_next     = swd_reg;
    wait_next    = wait_reg;
    swr_next     = 1'b0;
    sburst_next  = sburst_reg && !BUS.host_grant;
    case (s_state_reg)
      S_IDLE:
      begin
        if (!BUS.host_grant && (!BUS.wrh_n || !BUS.wrl_n || !BUS.rd_n))
        begin
          saddr_next   = (sburst_reg && !BUS.burst_n) ? scnt_reg : BUS.addr;
          sburst_next  = !BUS.burst_n;
          srd_next     = I_SLV_RDATA;
          wait_next    = `CNT_ZERO;
          s_state_next = BUS.rd_n ? S_RWAIT : S_RDATA;
        end
        else if (BUS.burst_n)
        begin
          sburst_next = 1'b0;
        end
      end
      S_RWAIT, S_RDATA:
      begin
        if (wait_reg != `CNT_W'(WAIT_CYC))
        begin
          wait_next = wait_reg + `CNT_ONE;
        end
        else
        begin
          swr_next     = (s_state_reg == S_RWAIT);
          swd_next     = BUS.data;
          scnt_next    = saddr_reg + `WORD_STEP;
          s_state_next = S_IDLE;
        end
      end
      default:
      begin
        s_state_next = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_B)
    begin
      m_state_reg <= M_IDLE;
      s_state_reg <= S_IDLE;
      addr_reg    <= '0;
      wdata_reg   <= '0;
      write_reg   <= 1'b0;
      wrh_n_reg   <= 1'b1;
      wrl_n_reg   <= 1'b1;
      rd_n_reg    <= 1'b1;
      burst_n_reg <= 1'b1;
      rsp_reg     <= '0;
      rspv_reg    <= 1'b0;
      req_reg     <= 1'b0;
      own_reg     <= `CNT_ZERO;
      saddr_reg   <= '0;
      scnt_reg    <= '0;
      srd_reg     <= '0;
      swd_reg     <= '0;
      wait_reg    <= `CNT_ZERO;
      swr_reg     <= 1'b0;
      sburst_reg  <= 1'b0;
    end
    else
    begin
      m_state_reg <= m_state_next;
      s_state_reg <= s_state_next;
      addr_reg    <= addr_next;
      wdata_reg   <= wdata_next;
      write_reg   <= write_next;
      wrh_n_reg   <= wrh_n_next;
      wrl_n_reg   <= wrl_n_next;
      rd_n_reg    <= rd_n_next;
      burst_n_reg <= burst_n_next;
      rsp_reg     <= rsp_next;
      rspv_reg    <= rspv_next;
      req_reg     <= req_next;
      own_reg     <= own_next;
      saddr_reg   <= saddr_next;
      scnt_reg    <= scnt_next;
      srd_reg     <= srd_next;
      swd_reg     <= swd_next;
      wait_reg    <= wait_next;
      swr_reg     <= swr_next;
      sburst_reg  <= sburst_next;
    end
  end
endmodule

/* File: testbench/ext_bus_assertions.sv */
// checker of the resolved bus lines
// assumes: tb wires it beside ext_bus_if
`timescale 1ns/1ps
module ext_bus_assertions (
  input wire logic        I_MCLK, I_RST_B, wrh_n, wrl_n, rd_n, ack, ms0_n, ms1_n, msh_n,
  input wire logic        dev_ctl_oe_n, dev_ack_oe_n, host_grant,
  input wire logic [31:0] addr
);
  default clocking @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_B);
  wire logic quiet = wrh_n && wrl_n && rd_n;
  wire logic act = !dev_ctl_oe_n && !quiet;
  wire logic calm = host_grant || quiet;
  bank0_sel_a: assert property (act |-> ms0_n == (addr[31:26] != 6'h02))
    else $error("bank0");
  bank1_sel_a: assert property (act |-> ms1_n == (addr[31:26] != 6'h03))
    else $error("bank1");
  host_sel_a: assert property (act |-> msh_n == (addr[31:28] == 4'h0))
    else $error("host space");
  wr_no_ack_a: assert property (host_grant && !(wrh_n && wrl_n) |-> dev_ack_oe_n)
    else $error("ack on write");
  master_only_a: assert property (host_grant |-> dev_ctl_oe_n && $past(calm))
    else $error("not released");
  rd_stall_a: assert property (host_grant && $fell(rd_n) |=> !ack)
    else $error("no stall");
  wait_hold_a: assert property (act && !ack |=> act && $stable(addr))
    else $error("wait ignored");
  access_end_a: assert property (act |-> ##[1:40] !act)
    else $error("hung");
endmodule

/* File: testbench/tb.sv */
// tb: both bus ends joined, random traffic with corners
// assumes: design files and checker compiled first
`timescale 1ns/1ps
module tb;
  logic        I_MCLK = 1'b0, I_RST_B = 1'b0, dv = 1'b0, hv = 1'b0, hq = 1'b0;
  logic        w = 1'b0, l = 1'b0, b = 1'b0, hb = 1'b0, bs = 1'b1;
  logic [31:0] a = '0, st = 32'h0000be05, base = '0;
  logic [63:0] wd = '0, rd = '0;
  wire logic   drdy, drv, hrdy, hown, hrv, hwv, swv, swh, swl, srq, boot;
  wire logic [31:0] sa, hsa;
  wire logic [63:0] drd, hrd, swd, hwd;
  int          n_fail = 0, n_checks = 0;
  ext_bus_if bus ();
  dev_bus_end dev_bus_end_i (.I_MCLK, .I_RST_B, .BUS(bus), .I_REQ_VALID(dv),
    .O_REQ_READY(drdy), .I_REQ_WRITE(w), .I_REQ_LONG(l), .I_REQ_BUS32(b), .I_REQ_BURST(hb),
    .I_REQ_ADDR(a), .I_REQ_WDATA(wd), .O_RD_VALID(drv), .I_RD_READY(1'b1), .O_RD_DATA(drd),
    .I_BOOT_DONE(hq), .O_BOOT_EPROM(boot), .O_HOST_GRANTED(), .O_SLV_ADDR(sa),
    .O_SLV_WR_VALID(swv), .O_SLV_WR_DATA(swd), .O_SLV_WR_HI(swh), .O_SLV_WR_LO(swl),
    .O_SLV_RD_REQ(srq), .I_SLV_RD_VALID(srq), .I_SLV_RD_DATA(rd));
  host_bus_end host_bus_end_i (.I_MCLK, .I_RST_B, .BUS(bus), .I_BOOT_STRAP(bs),
    .I_BUS_REQ(hq), .O_BUS_OWNED(hown), .I_REQ_VALID(hv), .O_REQ_READY(hrdy), .I_REQ_WRITE(w),
    .I_REQ_HI(l), .I_REQ_LO(b), .I_REQ_BURST(hb), .I_REQ_ADDR(a), .I_REQ_WDATA(wd),
    .O_RSP_VALID(hrv), .O_RSP_DATA(hrd), .O_SLV_ADDR(hsa), .O_SLV_WR_VALID(hwv),
    .O_SLV_WR_DATA(hwd), .I_SLV_RDATA(rd));
  ext_bus_assertions ext_bus_assertions_i (.I_MCLK, .I_RST_B, .wrh_n(bus.wrh_n),
    .wrl_n(bus.wrl_n), .rd_n(bus.rd_n), .ack(bus.ack), .ms0_n(bus.ms0_n), .ms1_n(bus.ms1_n),
    .msh_n(bus.msh_n), .dev_ctl_oe_n(bus.dev_ctl_oe_n), .dev_ack_oe_n(bus.dev_ack_oe_n),
    .host_grant(bus.host_grant), .addr(bus.addr));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [2:0] ex(input logic wr, lg, b3, a0);
    return wr ? {!(lg | (!b3 & a0)), !(lg | b3 | !a0), 1'b1} : 3'b110;
  endfunction
  task automatic chk(input logic [95:0] g, e);
    n_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: mismatch", $time);
    end
  endtask
  task automatic req(input logic h);
    {hv, dv} <= {h, !h};
    @(negedge I_MCLK);
    for (int k = 0; k < 40 && !(h ? hrdy : drdy); k++)
      @(negedge I_MCLK);
    @(posedge I_MCLK);
    {hv, dv} <= 2'b00;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial forever #50 I_MCLK = ~I_MCLK;
  initial
  begin
    #200us;
    n_fail++;
    tally_and_finish;
  end
  initial
  begin
    repeat (3) @(posedge I_MCLK);
    I_RST_B <= 1'b1;
    repeat (2) @(negedge I_MCLK);
    chk(boot, 1'b1);
    chk(bus.bms_n, 1'b0);
    for (int i = 0; i < 32; i++)
    begin
      @(posedge I_MCLK);
      st = xs(st);
      if (i == 12 || i == 20)
        base = st;
      hq <= i > 15;
      a <= i < 4 ? {5'h01, i[0], st[25:0]} : st;
      w <= i < 16 ? st[31] : i < 20;
      {l, b, hb} <= {st[30], st[29] | (i > 15 && !st[30]), i > 11 && (i < 16 || i > 19)};
      wd <= {st, ~st};
      rd <= {~st, st};
      req(i > 15);
      @(negedge I_MCLK);
      if (i < 16)
        chk({bus.wrh_n, bus.wrl_n, bus.rd_n, bus.burst_n, bus.addr},
            {ex(w, l, b, a[0]), !hb, a});
      for (int k = 0; k < 40 && !(i < 16 ? (w ? hwv : drv) : (w ? swv : hrv)); k++)
        @(negedge I_MCLK);
      if (i < 16)
        chk({w ? hwd : drd, hsa},
            {w ? wd : rd, i > 11 ? base + 32'(i - 12) : a});
      else if (w)
        chk({swh, swl, swd}, {l, b, wd});
      else
        chk({sa, hrd}, {base + 32'(i - 20), rd});
    end
    @(posedge I_MCLK);
    {hq, bs, I_RST_B} <= 3'b000;
    repeat (3) @(posedge I_MCLK);
    I_RST_B <= 1'b1;
    repeat (2) @(negedge I_MCLK);
    chk({boot, bus.bms_n}, 2'b01);
    tally_and_finish;
  end
endmodule
